// *** hdl/swsc_pkg.sv ***
package swsc_pkg;

    // ==========================================================
    // Register map and fields
    // ==========================================================
    localparam logic [3:0]  SWSC_ADDR_STANDBY_CONTROL = 4'h0;
    localparam logic [3:0]  SWSC_ADDR_STATUS          = 4'h1;
    localparam int          SWSC_ADDR_W               = 4;
    localparam int          SWSC_DATA_W               = 16;
    localparam int          SWSC_BIT_SOFT_STANDBY     = 15;
    localparam int          SWSC_BIT_OUT_PORT_ENABLE  = 14;
    localparam int          SWSC_BIT_RSVD13           = 13;
    localparam int          SWSC_WAIT_SEL_HI          = 12;
    localparam int          SWSC_WAIT_SEL_LO          = 8;
    localparam int          SWSC_BIT_SLEEP_EXC        = 7;
    localparam logic [4:0]  SWSC_WAIT_SEL_RESET       = 5'h0f;
    localparam logic        SWSC_OPE_RESET            = 1'b1;

    // Status register bits
    localparam int          SWSC_STAT_BIT_STANDBY     = 0;
    localparam int          SWSC_STAT_BIT_SLEEP       = 1;
    localparam int          SWSC_STAT_BIT_SETTLING    = 2;
    localparam int          SWSC_STAT_BIT_BADSEL      = 3;

    // ==========================================================
    // Settling counter
    // ==========================================================
    localparam int          SWSC_CNT_W                = 20;
    localparam logic [19:0] SWSC_CNT_ZERO             = 20'h0_0000;
    localparam logic [19:0] SWSC_CNT_ONE              = 20'h0_0001;
    localparam int          SWSC_PCLK_DIV             = 4;

    typedef enum logic [3:0] {
        SWSC_RUN    = 4'b0001,
        SWSC_SLEEP  = 4'b0010,
        SWSC_STBY   = 4'b0100,
        SWSC_SETTLE = 4'b1000
    } swsc_state_t;

    // Decode wait select code into state count; zero marks reserved codes
    function automatic logic [19:0] swsc_wait_states(input logic [4:0] sel);
        logic [19:0] n;
        n = SWSC_CNT_ZERO;
        unique case (sel)
            5'h05: n = 20'h0_0040;
            5'h06: n = 20'h0_0200;
            5'h07: n = 20'h0_0400;
            5'h08: n = 20'h0_0800;
            5'h09: n = 20'h0_1000;
            5'h0a: n = 20'h0_4000;
            5'h0b: n = 20'h0_8000;
            5'h0c: n = 20'h1_0000;
            5'h0d: n = 20'h2_0000;
            5'h0e: n = 20'h4_0000;
            5'h0f: n = 20'h8_0000;
            default: n = SWSC_CNT_ZERO;
        endcase
        return n;
    endfunction

endpackage

// *** hdl/swsc_wait_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface swsc_wait_if;
    logic        start;
    logic        tick;
    logic [19:0] target;
    logic        done;
    logic        busy;
    modport ctl (output start, output tick, output target, input done, input busy);
    modport cnt (input start, input tick, input target, output done, output busy);
endinterface
`default_nettype wire

// *** hdl/swsc_settle_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module swsc_settle_counter
    import swsc_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  resetn,
    swsc_wait_if.cnt   w
);
    logic [19:0] count_q;
    logic        busy_q;
    logic        done_q;

    assign w.busy = busy_q;
    assign w.done = done_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= SWSC_CNT_ZERO;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (w.start) begin
                count_q <= SWSC_CNT_ZERO;
                busy_q  <= 1'b1;
            end else if (busy_q && w.tick) begin
                if (count_q + SWSC_CNT_ONE >= w.target) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                count_q <= count_q + SWSC_CNT_ONE;
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/swsc_standby_ctl.sv ***
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Bit 13 reads zero; software writes zero.
// - Five-bit select field picks clock settling wait after standby wake.
// - Select field resets to 01111, the 524288-state wait.
// - External interrupt ends standby; execution held until count expires.
// - Settling counter advances once per peripheral clock state.
// - Codes 00101..01001 give 64..4096 states; others below, and 1xxxx, reserved.
// - Codes 01010..01111 give 16384..524288 states.
// - Sleep exception enable resets zero; then SLEEP enters power-down.
// - With enable set, SLEEP starts exception processing instead.
// - Enable stays set after exception; hardware never clears it.
// - Software writing zero clears the enable.
// - Bits 6..0 read zero; software writes zero.
// - Standby select: 0 means sleep mode, 1 means software standby.
// - Standby select stays set after wake until software clears it.
module swsc_standby_ctl
    import swsc_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       resetn,
    input  wire logic [SWSC_ADDR_W-1:0]     reg_addr,
    input  wire logic [SWSC_DATA_W-1:0]     reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [SWSC_DATA_W-1:0]     reg_rdata,
    input  wire logic                       sleep_exec,
    input  wire logic                       ext_irq,
    input  wire logic                       wake_irq,
    output logic                            sleep_exc_req,
    output logic                            cpu_clk_en,
    output logic                            periph_clk_en,
    output logic                            osc_stop,
    output logic                            bus_hold_out,
    output logic                            ext_irq_service
);
    import swsc_pkg::*;

    // ==========================================================
    // Register state
    // ==========================================================
    logic        soft_standby_select_q;
    logic        out_port_enable_q;
    logic [4:0]  wake_wait_select_q;
    logic        sleep_exception_enable_q;
    swsc_state_t state_q;
    swsc_state_t state_d;
    logic [1:0]  div_q;
    logic        pclk_tick;
    logic        sel_bad;
    logic        wr_ctl;

    swsc_wait_if wif();

    assign wr_ctl  = reg_wr && (reg_addr == SWSC_ADDR_STANDBY_CONTROL);
    assign sel_bad = (swsc_wait_states(wake_wait_select_q) == SWSC_CNT_ZERO);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            soft_standby_select_q <= 1'b0;
            out_port_enable_q     <= SWSC_OPE_RESET;
        end else if (wr_ctl) begin
            // only a write clears standby select
            soft_standby_select_q <= reg_wdata[SWSC_BIT_SOFT_STANDBY];
            out_port_enable_q     <= reg_wdata[SWSC_BIT_OUT_PORT_ENABLE];
        end
    end

    // wait select, reset to longest wait
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wake_wait_select_q <= SWSC_WAIT_SEL_RESET;
        end else if (wr_ctl) begin
            wake_wait_select_q <= reg_wdata[SWSC_WAIT_SEL_HI:SWSC_WAIT_SEL_LO];
        end
    end

    // enable resets low, only software changes it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sleep_exception_enable_q <= 1'b0;
        end else if (wr_ctl) begin
            sleep_exception_enable_q <= reg_wdata[SWSC_BIT_SLEEP_EXC];
        end
    end

    // ==========================================================
    // Read port
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= 16'h0000;
            unique case (reg_addr)
                SWSC_ADDR_STANDBY_CONTROL: begin
                    reg_rdata[SWSC_BIT_SOFT_STANDBY]               <= soft_standby_select_q;
                    reg_rdata[SWSC_BIT_OUT_PORT_ENABLE]            <= out_port_enable_q;
                    reg_rdata[SWSC_WAIT_SEL_HI:SWSC_WAIT_SEL_LO]   <= wake_wait_select_q;
                    reg_rdata[SWSC_BIT_SLEEP_EXC]                  <= sleep_exception_enable_q;
                end
                SWSC_ADDR_STATUS: begin
                    reg_rdata[SWSC_STAT_BIT_STANDBY]  <= (state_q == SWSC_STBY);
                    reg_rdata[SWSC_STAT_BIT_SLEEP]    <= (state_q == SWSC_SLEEP);
                    reg_rdata[SWSC_STAT_BIT_SETTLING] <= (state_q == SWSC_SETTLE);
                    reg_rdata[SWSC_STAT_BIT_BADSEL]   <= sel_bad;
                end
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ==========================================================
    // Peripheral clock state enable
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 2'd0;
        end else begin
            div_q <= div_q + 2'd1;
        end
    end
    assign pclk_tick = (div_q == 2'(SWSC_PCLK_DIV - 1));

    // ==========================================================
    // Power state machine
    // ==========================================================
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SWSC_RUN: begin
                if (sleep_exec && !sleep_exception_enable_q) begin
                    state_d = soft_standby_select_q ? SWSC_STBY : SWSC_SLEEP;
                end
            end
            SWSC_SLEEP: begin
                if (wake_irq || ext_irq) begin
                    state_d = SWSC_RUN;
                end
            end
            SWSC_STBY: begin
                if (ext_irq) begin
                    state_d = SWSC_SETTLE;
                end
            end
            SWSC_SETTLE: begin
                if (wif.done) begin
                    state_d = SWSC_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SWSC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    assign wif.start  = (state_q == SWSC_RUN) && (state_d == SWSC_STBY);
    // ticks only while settling; time spent in standby must not eat the wait
    assign wif.tick   = pclk_tick && (state_q == SWSC_SETTLE);
    // reserved codes fall back to the longest wait for safety
    assign wif.target = sel_bad ? swsc_wait_states(SWSC_WAIT_SEL_RESET)
                                : swsc_wait_states(wake_wait_select_q);

    swsc_settle_counter u_counter (
        .core_clk (core_clk),
        .resetn   (resetn),
        .w        (wif.cnt)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sleep_exc_req   <= 1'b0;
            cpu_clk_en      <= 1'b1;
            periph_clk_en   <= 1'b1;
            osc_stop        <= 1'b0;
            bus_hold_out    <= SWSC_OPE_RESET;
            ext_irq_service <= 1'b0;
        end else begin
            sleep_exc_req   <= (state_q == SWSC_RUN) && sleep_exec && sleep_exception_enable_q;
            // CPU held until return to run
            cpu_clk_en      <= (state_d == SWSC_RUN);
            periph_clk_en   <= (state_d == SWSC_RUN) || (state_d == SWSC_SLEEP)
                               || (state_d == SWSC_SETTLE);
            osc_stop        <= (state_d == SWSC_STBY);
            bus_hold_out    <= out_port_enable_q;
            ext_irq_service <= (state_q == SWSC_SETTLE) && wif.done;
        end
    end

endmodule
`default_nettype wire

// *** testbench/swsc_standby_ctl_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module swsc_standby_ctl_props (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        sleep_exec,
    input wire logic        ext_irq,
    input wire logic        sleep_exc_req,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        osc_stop,
    input wire logic        ext_irq_service
);
    logic [19:0] settle_q;

    // ==========================================================
    // Settling span, counted while the core is stopped but the oscillator runs
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            settle_q <= 20'h0_0000;
        end else if (osc_stop || cpu_clk_en) begin
            settle_q <= 20'h0_0000;
        end else begin
            settle_q <= settle_q + 20'h0_0001;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence wake_seq;
        osc_stop && ext_irq ##1 !osc_stop;
    endsequence
    sequence settle_seq;
        !cpu_clk_en && periph_clk_en;
    endsequence

    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    chk_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |->
        reg_rdata[13] == 1'b0 && reg_rdata[6:0] == 7'h00)
        else $error("reserved control bits read nonzero");
    chk_exc_no_down: assert property (sleep_exc_req |->
        $past(sleep_exec) && cpu_clk_en && !osc_stop)
        else $error("exception request without sleep or with power-down");
    chk_sleep_cause: assert property ($fell(cpu_clk_en) |-> $past(sleep_exec))
        else $error("core clock stopped without sleep");
    chk_standby_pins: assert property (osc_stop == !periph_clk_en)
        else $error("oscillator and peripheral clock disagree");
    chk_wake_settle: assert property (wake_seq |-> settle_seq)
        else $error("standby exit did not enter settling");
    chk_leave_cause: assert property ($fell(osc_stop) |-> $past(ext_irq))
        else $error("standby left without external interrupt");
    chk_service_edge: assert property (ext_irq_service |->
        cpu_clk_en && !$past(cpu_clk_en))
        else $error("service pulse not with clock release");
    chk_settle_min: assert property (ext_irq_service |-> settle_q >= 20'h0_00fc)
        else $error("settling shorter than shortest wait");
endmodule

bind swsc_standby_ctl swsc_standby_ctl_props chk (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_exec(sleep_exec), .ext_irq(ext_irq),
    .sleep_exc_req(sleep_exc_req), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_stop(osc_stop),
    .ext_irq_service(ext_irq_service));
`default_nettype wire

// *** testbench/swsc_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module swsc_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       cpu_clk_en,
    input  wire logic [2:0] cmd,
    output logic            sleep_exec,
    output logic            ext_irq,
    output logic            wake_irq
);
    // ==========================================================
    // Core side: a stopped core cannot issue SLEEP, so it is gated
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sleep_exec <= 1'b0;
            ext_irq    <= 1'b0;
            wake_irq   <= 1'b0;
        end else begin
            sleep_exec <= cmd[2] && cpu_clk_en;
            ext_irq    <= cmd[1];
            wake_irq   <= cmd[0];
        end
    end
endmodule
`default_nettype wire

// *** testbench/swsc_standby_ctl_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module swsc_standby_ctl_bench;
    logic        core_clk  = 1'b0;
    logic        resetn    = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [2:0]  cmd       = 3'b000;
    logic [15:0] reg_rdata;
    logic        sleep_exec, ext_irq, wake_irq, sleep_exc_req, cpu_clk_en;
    logic        periph_clk_en, osc_stop, bus_hold_out, ext_irq_service;
    int          failures  = 0;
    int          n_tests   = 0;

    always #2 core_clk = ~core_clk;

    swsc_standby_ctl DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_exec(sleep_exec), .ext_irq(ext_irq), .wake_irq(wake_irq),
        .sleep_exc_req(sleep_exc_req), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_stop(osc_stop),
        .bus_hold_out(bus_hold_out), .ext_irq_service(ext_irq_service));
    swsc_cpu_model cpu (.core_clk(core_clk), .resetn(resetn), .cpu_clk_en(cpu_clk_en),
        .cmd(cmd), .sleep_exec(sleep_exec), .ext_irq(ext_irq), .wake_irq(wake_irq));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    // Command bits: sleep, external interrupt, other interrupt
    task automatic go(input logic [2:0] m, input int settle);
        @(posedge core_clk);
        cmd <= m;
        @(posedge core_clk);
        cmd <= 3'b000;
        repeat (settle) @(posedge core_clk);
        #1;
    endtask

    task automatic t_regs;
        rd(4'h0, 16'h4f00);
        rd(4'h7, 16'h0000);
        wr(4'h7, 16'hffff);
        rd(4'h0, 16'h4f00);
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'hdf80);
        rd(4'h1, 16'h0008);
        check(bus_hold_out, 1'b1);
        wr(4'h0, 16'h0500);
        rd(4'h0, 16'h0500);
        check(bus_hold_out, 1'b0);
    endtask
    task automatic t_exc;
        int seen;
        seen = 0;
        // Standby select kept clear while the exception is enabled
        wr(4'h0, 16'h0580);
        go(3'b100, 0);
        repeat (4) begin
            @(posedge core_clk);
            #1;
            if (sleep_exc_req === 1'b1)
                seen++;
        end
        check(seen, 1);
        check(cpu_clk_en, 1'b1);
        rd(4'h0, 16'h0580);
        wr(4'h0, 16'h0500);
        rd(4'h0, 16'h0500);
    endtask
    task automatic t_sleep;
        go(3'b100, 4);
        check({osc_stop, periph_clk_en, cpu_clk_en}, 3'b010);
        rd(4'h1, 16'h0002);
        go(3'b001, 8);
        check(cpu_clk_en, 1'b1);
        // Sleep is also left by the external interrupt
        go(3'b100, 4);
        check(cpu_clk_en, 1'b0);
        go(3'b010, 8);
        check(cpu_clk_en, 1'b1);
    endtask
    task automatic t_standby(input logic [4:0] code, input int n);
        logic [15:0] v;
        int          c;
        v = {3'b100, code, 8'h00};
        wr(4'h0, v);
        rd(4'h0, v);
        go(3'b100, 4);
        check({osc_stop, periph_clk_en, cpu_clk_en}, 3'b100);
        rd(4'h1, 16'h0001);
        go(3'b001, 4);
        check(osc_stop, 1'b1);
        go(3'b010, 0);
        c = 0;
        while (ext_irq_service !== 1'b1 && c < n * 4 + 20) begin
            @(posedge core_clk);
            #1;
            c++;
        end
        check(c >= n * 4 - 4 && c <= n * 4 + 8, 1'b1);
        check(cpu_clk_en, 1'b1);
        rd(4'h0, v);
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_exc();
        t_sleep();
        // Short codes keep the run brief; one long code still crosses a decade
        t_standby(5'h05, 64);
        t_standby(5'h06, 512);
        t_standby(5'h07, 1024);
        t_standby(5'h08, 2048);
        t_standby(5'h0a, 16384);
        close_out();
    end

    initial begin
        repeat (95000) @(posedge core_clk);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
